// >>> sdbd_defines.svh
// Constants for the diagnostic data buffer command block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SDBD_DEFINES_SVH
`define SDBD_DEFINES_SVH

// Operation codes and command block layout
`define SDBD_OP_WRBUF 8'h3b
`define SDBD_OP_RDBUF 8'h3c
`define SDBD_CDB_BYTES 10
`define SDBD_LUN_MSB 7
`define SDBD_LUN_LSB 5
`define SDBD_ALLOC_MSB_BYTE 7
`define SDBD_ALLOC_LSB_BYTE 8
`define SDBD_HDR_BYTES 3'h4

// Available buffer length in the returned header
`define SDBD_AVAIL_MSB 8'h20
`define SDBD_AVAIL_LSB 8'h00
`define SDBD_BUF_BYTES 8192

// Error codes and sense keys
`define SDBD_ERR_NONE 8'h00
`define SDBD_ERR_DEFECT 8'h19
`define SDBD_ERR_ILLCMD 8'h20
`define SDBD_ERR_LUN 8'h25
`define SDBD_ERR_FIELD 8'h26
`define SDBD_ERR_THRESH 8'h2c
`define SDBD_ERR_PARITY 8'h47
`define SDBD_KEY_NONE 4'h0
`define SDBD_KEY_RECOVERED 4'h1
`define SDBD_KEY_HWERR 4'h4
`define SDBD_KEY_ILLEGAL 4'h5
`define SDBD_KEY_ATTN 4'h6

`endif

// >>> sdbd_pkg.sv
// Types shared by the diagnostic buffer command block.
// Assumes sdbd_defines.svh on the include path.
`include "sdbd_defines.svh"
package sdbd_pkg;
  typedef logic [`SDBD_CDB_BYTES-1:0][7:0] sdbd_cdb_t;
  typedef enum logic [2:0] {
    IDLE, WR_HDR, WR_DATA, RD_HDR, RD_FETCH, RD_SEND, FINISH
  } sdbd_state_e;
endpackage

// >>> sdbd_mem_if.sv
// Port bundle between the command logic and its buffer memory.
// Assumes a single clock; all signals are driven in that domain.
`timescale 1ns/1ps
interface sdbd_mem_if #(parameter int AW = 13);
  logic we;
  logic re;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output re, output addr, output wdata, input rdata);
  modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

// >>> sdbd_buf_mem.sv
// Byte-wide data buffer with registered read data.
// Assumes one access per cycle; read data hold until the next read.
`timescale 1ns/1ps
module sdbd_buf_mem #(
  parameter int DEPTH = 8192
) (
  // Clock
  input wire logic clk,
  // Access port
  sdbd_mem_if.mem port
);
  logic [7:0] store [DEPTH];
  logic [7:0] rdata;

  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    if (port.re) begin
      rdata <= store[port.addr];
    end
  end

  assign port.rdata = rdata;
endmodule // sdbd_buf_mem

// >>> sdbd_diag_cmd.sv
// Diagnostic buffer write and read command handling for the target logic.
// Assumes a decoded ten-byte command block, byte streams with valid/ready,
// and a sense request path that consumes the stored error.
//
// Contract
// RULE1: Write buffer is opcode 3Bh, LUN byte1 top
// RULE2: Read buffer is opcode 3Ch, length bytes 7-8
// RULE3: Write length counts four-byte header plus data
// RULE4: Read length counts four-byte header plus data
// RULE5: Write stops at length or 8K, first
// RULE6: Read stops at length or 8K, first
// RULE7: Short allocation length truncates, no error
// RULE8: Zero length moves nothing, no error
// RULE9: Read header bytes 2-3 are 20h 00h
// RULE10: Written data can be read back
// RULE11: Unsupported LUN gives 25h, key 5
// RULE12: Invalid parameter field gives 26h, key 5
// RULE13: Initiator data parity error gives 47h, key 4
// RULE14: Threshold exceeded gives 2Ch, key 6
// RULE15: Read may fail defect list: 19h, key 1
// RULE16: Data stored and read from offset zero
// RULE17: Error code and key kept for sense
`timescale 1ns/1ps
`include "sdbd_defines.svh"
module sdbd_diag_cmd
  import sdbd_pkg::*;
#(
  parameter int BUF_BYTES = `SDBD_BUF_BYTES,
  parameter logic [2:0] SUPPORTED_LUN = 3'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command block
  input wire logic cdbValid,
  input wire sdbd_cdb_t cdb,
  output logic cdbReady,
  // Data from initiator
  input wire logic inValid,
  input wire logic [7:0] inData,
  input wire logic inParity,
  output logic inReady,
  // Data to initiator
  output logic outValid,
  output logic [7:0] outData,
  input wire logic outReady,
  // Conditions
  input wire logic thresholdExceeded,
  input wire logic defectListFail,
  // Completion and sense
  output logic cmdDone,
  output logic cmdCheck,
  output logic [7:0] senseCode,
  output logic [3:0] senseKey,
  input wire logic senseTaken
);
  localparam int AW = $clog2(BUF_BYTES);
  localparam int IW = AW + 1;
  localparam logic [IW-1:0] BUF_END = IW'(BUF_BYTES);

  // Refused while elaborating, so a bad size never reaches a netlist
  if (BUF_BYTES < 256 || BUF_BYTES > 32768 || (1 << AW) != BUF_BYTES) begin : gBadBufBytes
    $error("BUF_BYTES must be a power of two from 256 to 32768");
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer memory
  sdbd_mem_if #(.AW(AW)) memBus ();
  sdbd_buf_mem #(.DEPTH(BUF_BYTES)) bufMem (
    .clk(clk),
    .port(memBus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Header byte returned by a buffer read
  function automatic logic [7:0] rdHeaderByte(input logic [1:0] idx);
    unique case (idx)
      2'h2: rdHeaderByte = `SDBD_AVAIL_MSB; // RULE9
      2'h3: rdHeaderByte = `SDBD_AVAIL_LSB; // RULE9
      default: rdHeaderByte = 8'h00;
    endcase
  endfunction

  sdbd_state_e state, next_state;
  logic [15:0] alloc, next_alloc;
  logic [15:0] byteCnt, next_byteCnt;
  logic [IW-1:0] dataIdx, next_dataIdx;
  logic [1:0] hdrIdx, next_hdrIdx;
  logic hdrBad, next_hdrBad;
  logic [7:0] errCode, next_errCode;
  logic [3:0] errKey, next_errKey;
  logic [7:0] next_senseCode;
  logic [3:0] next_senseKey;

  logic [7:0] opcode;
  logic [2:0] cdbLun;
  logic [15:0] cdbAlloc;
  logic parityOk;
  logic [15:0] cntInc;
  logic [IW-1:0] idxInc;

  assign opcode = cdb[0];
  assign cdbLun = cdb[1][`SDBD_LUN_MSB:`SDBD_LUN_LSB];
  assign cdbAlloc = {cdb[`SDBD_ALLOC_MSB_BYTE], cdb[`SDBD_ALLOC_LSB_BYTE]};
  assign parityOk = ^{inData, inParity};
  assign cntInc = byteCnt + 16'h0001;
  assign idxInc = dataIdx + IW'(1);

  assign cdbReady = (state == IDLE);
  assign inReady = (state == WR_HDR) || (state == WR_DATA);
  assign outValid = (state == RD_HDR) || (state == RD_SEND);
  // Read data come from the memory flop; the header byte is decoded from the hdrIdx flop
  assign outData = (state == RD_SEND) ? memBus.rdata : rdHeaderByte(hdrIdx);
  assign cmdDone = (state == FINISH);
  assign cmdCheck = (state == FINISH) && (errCode != `SDBD_ERR_NONE);

  // Data land from offset zero; reads fetch the same offsets
  assign memBus.addr = dataIdx[AW-1:0]; // RULE16 RULE10
  assign memBus.wdata = inData;
  assign memBus.we = (state == WR_DATA) && inValid && parityOk;
  assign memBus.re = (state == RD_FETCH);

  ////////////////////////////////////////////////////////////////////////
  // Command sequencing
  always_comb begin
    next_state = state;
    next_alloc = alloc;
    next_byteCnt = byteCnt;
    next_dataIdx = dataIdx;
    next_hdrIdx = hdrIdx;
    next_hdrBad = hdrBad;
    next_errCode = errCode;
    next_errKey = errKey;
    unique case (state)
      IDLE: begin
        if (cdbValid) begin
          next_alloc = cdbAlloc;
          next_byteCnt = 16'h0000;
          next_dataIdx = '0;
          next_hdrIdx = 2'h0;
          next_hdrBad = 1'b0;
          next_errCode = `SDBD_ERR_NONE;
          next_errKey = `SDBD_KEY_NONE;
          next_state = FINISH;
          if (opcode != `SDBD_OP_WRBUF && opcode != `SDBD_OP_RDBUF) begin // RULE1 RULE2
            next_errCode = `SDBD_ERR_ILLCMD;
            next_errKey = `SDBD_KEY_ILLEGAL;
          end else if (cdbLun != SUPPORTED_LUN) begin
            next_errCode = `SDBD_ERR_LUN; // RULE11
            next_errKey = `SDBD_KEY_ILLEGAL; // RULE11
          end else if (thresholdExceeded) begin
            next_errCode = `SDBD_ERR_THRESH; // RULE14
            next_errKey = `SDBD_KEY_ATTN; // RULE14
          end else if (opcode == `SDBD_OP_RDBUF && defectListFail) begin
            next_errCode = `SDBD_ERR_DEFECT; // RULE15
            next_errKey = `SDBD_KEY_RECOVERED; // RULE15
          end else if (cdbAlloc == 16'h0000) begin
            next_state = FINISH; // RULE8
          end else if (opcode == `SDBD_OP_WRBUF) begin
            next_state = WR_HDR; // RULE1
          end else begin
            next_state = RD_HDR; // RULE2
          end
        end
      end
      WR_HDR: begin
        if (inValid) begin
          if (!parityOk) begin
            next_errCode = `SDBD_ERR_PARITY; // RULE13
            next_errKey = `SDBD_KEY_HWERR; // RULE13
            next_state = FINISH;
          end else begin
            // Header counts against the length and is not stored
            next_byteCnt = cntInc; // RULE3
            next_hdrIdx = hdrIdx + 2'h1;
            next_hdrBad = hdrBad || (inData != 8'h00);
            if (hdrIdx == 2'h3 && (hdrBad || inData != 8'h00)) begin
              next_errCode = `SDBD_ERR_FIELD; // RULE12
              next_errKey = `SDBD_KEY_ILLEGAL; // RULE12
              next_state = FINISH;
            end else if (cntInc == alloc) begin
              next_state = FINISH; // RULE7
            end else if (hdrIdx == 2'h3) begin
              next_state = WR_DATA;
            end
          end
        end
      end
      WR_DATA: begin
        if (inValid) begin
          if (!parityOk) begin
            next_errCode = `SDBD_ERR_PARITY; // RULE13
            next_errKey = `SDBD_KEY_HWERR; // RULE13
            next_state = FINISH;
          end else begin
            next_byteCnt = cntInc;
            next_dataIdx = idxInc;
            if (cntInc == alloc || idxInc == BUF_END) begin
              next_state = FINISH; // RULE5 RULE7
            end
          end
        end
      end
      RD_HDR: begin
        if (outReady) begin
          next_byteCnt = cntInc; // RULE4
          next_hdrIdx = hdrIdx + 2'h1;
          if (cntInc == alloc) begin
            next_state = FINISH; // RULE7
          end else if (hdrIdx == 2'h3) begin
            next_state = RD_FETCH;
          end
        end
      end
      RD_FETCH: begin
        next_state = RD_SEND;
      end
      RD_SEND: begin
        if (outReady) begin
          next_byteCnt = cntInc;
          next_dataIdx = idxInc;
          if (cntInc == alloc || idxInc == BUF_END) begin
            next_state = FINISH; // RULE6 RULE7
          end else begin
            next_state = RD_FETCH;
          end
        end
      end
      FINISH: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= IDLE;
      alloc <= 16'h0000;
      byteCnt <= 16'h0000;
      dataIdx <= '0;
      hdrIdx <= 2'h0;
      hdrBad <= 1'b0;
      errCode <= `SDBD_ERR_NONE;
      errKey <= `SDBD_KEY_NONE;
    end else begin
      state <= next_state;
      alloc <= next_alloc;
      byteCnt <= next_byteCnt;
      dataIdx <= next_dataIdx;
      hdrIdx <= next_hdrIdx;
      hdrBad <= next_hdrBad;
      errCode <= next_errCode;
      errKey <= next_errKey;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sense data; a new check condition wins over a clear in the same cycle
  always_comb begin
    next_senseCode = senseCode;
    next_senseKey = senseKey;
    if (cmdCheck) begin
      next_senseCode = errCode; // RULE17
      next_senseKey = errKey; // RULE17
    end else if (senseTaken) begin
      next_senseCode = `SDBD_ERR_NONE;
      next_senseKey = `SDBD_KEY_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      senseCode <= `SDBD_ERR_NONE;
      senseKey <= `SDBD_KEY_NONE;
    end else begin
      senseCode <= next_senseCode;
      senseKey <= next_senseKey;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_WR_LIMIT: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    (state == WR_DATA) |-> (byteCnt < alloc) && (dataIdx < BUF_END))
    else $error("write ran past length or buffer");
  AST_RD_LIMIT: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    (state == RD_SEND) |-> (byteCnt < alloc) && (dataIdx < BUF_END))
    else $error("read ran past length or buffer");
  AST_TRUNC_OK: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    (state == RD_SEND && outReady && cntInc == alloc) |=> cmdDone && !cmdCheck)
    else $error("truncated read did not end cleanly");
  AST_ZERO_LEN: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    (state == IDLE && cdbValid && cdbAlloc == 16'h0000 && cdbLun == SUPPORTED_LUN
      && !thresholdExceeded && (opcode == `SDBD_OP_WRBUF
      || (opcode == `SDBD_OP_RDBUF && !defectListFail)))
    |=> (cmdDone && !cmdCheck) ##1 (state == IDLE))
    else $error("zero length command moved data or raised an error");
  AST_AVAIL_LEN: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    (state == RD_HDR && hdrIdx == 2'h2) |-> outValid && outData == `SDBD_AVAIL_MSB)
    else $error("available length header byte wrong");
  AST_BAD_LUN: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    (state == IDLE && cdbValid && opcode == `SDBD_OP_RDBUF && cdbLun != SUPPORTED_LUN)
    |=> cmdCheck && errCode == `SDBD_ERR_LUN && errKey == `SDBD_KEY_ILLEGAL)
    else $error("bad unit not reported");
  AST_PARITY: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    (inReady && inValid && !parityOk) |=> cmdCheck && errCode == `SDBD_ERR_PARITY)
    else $error("parity error not reported");
  AST_DEFECT: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
    (state == IDLE && cdbValid && opcode == `SDBD_OP_WRBUF) |=> errCode != `SDBD_ERR_DEFECT)
    else $error("write ended with defect list error");
  AST_WR_ORIGIN: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    (state == WR_HDR && next_state == WR_DATA) |=> memBus.addr == '0)
    else $error("write data not stored from offset zero");
  AST_SENSE: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
    cmdCheck |=> senseCode == $past(errCode) && senseKey == $past(errKey))
    else $error("sense not captured");
endmodule // sdbd_diag_cmd

// >>> sdbd_initiator.sv
// Behavioural initiator on the two byte streams of the diagnostic block.
// Assumes one clock; the testbench top calls its tasks right after an edge.
`timescale 1ns/1ps
module sdbd_initiator (
  // Clock
  input wire logic clk,
  // Stream to target
  output logic inValid,
  output logic [7:0] inData,
  output logic inParity,
  input wire logic inReady,
  // Stream from target
  input wire logic outValid,
  input wire logic [7:0] outData,
  output logic outReady
);
  initial begin
    inValid = 1'b0;
    inData = 8'h00;
    inParity = 1'b0;
    outReady = 1'b0;
  end

  // Header and data leave as one stream; badIdx flips the parity of one byte
  task automatic send(input logic [7:0] b[$], input int badIdx, input bit slow,
                      output int taken);
    int k;
    taken = 0;
    for (int i = 0; i < b.size(); i++) begin
      inValid <= 1'b1;
      inData <= b[i];
      inParity <= ~^b[i] ^ (i == badIdx);
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (inReady !== 1'b1 && k < 40);
      if (inReady !== 1'b1) break;
      taken++;
      if (slow) begin
        inValid <= 1'b0;
        inData <= ~b[i];
        @(posedge clk);
      end
    end
    // A released line must not keep showing the last byte
    inValid <= 1'b0;
    inData <= ~b[b.size() - 1];
  endtask

  // Collects every byte taken during a fixed number of cycles
  task automatic recv(output logic [7:0] got[$], input int cycles, input bit slow);
    got = {};
    for (int i = 0; i < cycles; i++) begin
      @(posedge clk);
      if (outValid === 1'b1 && outReady) got.push_back(outData);
      outReady <= (i == cycles - 1) ? 1'b0 : (slow ? ~outReady : 1'b1);
    end
  endtask
endmodule // sdbd_initiator

// >>> tb.sv
// Self-checking testbench for the diagnostic buffer command block.
// Assumes the design files and the initiator model are compiled first.
`timescale 1ns/1ps
`include "sdbd_defines.svh"
module tb;
  import sdbd_pkg::*;
  localparam int BUF = 256;
  logic clk, sys_rst, cdbValid, cdbReady, inValid, inParity, inReady, outValid, outReady;
  logic thresholdExceeded, defectListFail, cmdDone, cmdCheck, senseTaken, lastCheck;
  logic [7:0] inData, outData, senseCode;
  logic [3:0] senseKey;
  sdbd_cdb_t cdb;
  int error_cnt, n_tests, doneCnt, doneMark, cyc, taken;
  logic [7:0] stream[$], got[$];

  sdbd_diag_cmd #(.BUF_BYTES(BUF), .SUPPORTED_LUN(3'h0)) sdbd_diag_cmd_inst (
    .clk(clk), .sys_rst(sys_rst), .cdbValid(cdbValid), .cdb(cdb), .cdbReady(cdbReady),
    .inValid(inValid), .inData(inData), .inParity(inParity), .inReady(inReady),
    .outValid(outValid), .outData(outData), .outReady(outReady),
    .thresholdExceeded(thresholdExceeded), .defectListFail(defectListFail),
    .cmdDone(cmdDone), .cmdCheck(cmdCheck), .senseCode(senseCode), .senseKey(senseKey),
    .senseTaken(senseTaken));
  sdbd_initiator sdbd_initiator_inst (
    .clk(clk), .inValid(inValid), .inData(inData), .inParity(inParity), .inReady(inReady),
    .outValid(outValid), .outData(outData), .outReady(outReady));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Done is a one-cycle pulse, so it is counted here rather than polled
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmdDone === 1'b1) begin
      doneCnt <= doneCnt + 1;
      lastCheck <= cmdCheck;
    end
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 8'h25 + 8'h11 + (i >> 8));
  endfunction

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic mk(input int n, input int ofs);
    stream = {};
    for (int i = 0; i < n; i++) stream.push_back(i < 4 ? 8'h00 : pat(i - 4 + ofs));
  endtask

  task automatic issue(input logic [7:0] op, input logic [2:0] lun, input logic [15:0] len);
    sdbd_cdb_t c;
    int k;
    c = '0;
    c[0] = op;
    c[1] = {lun, 5'h00};
    c[7] = len[15:8];
    c[8] = len[7:0];
    doneMark = doneCnt;
    k = 0;
    @(posedge clk);
    cdbValid <= 1'b1;
    cdb <= c;
    do begin
      @(posedge clk);
      k++;
    end while (cdbReady !== 1'b1 && k < 50);
    cdbValid <= 1'b0;
  endtask

  task automatic endcmd(input logic chkExp, input logic [7:0] code, input logic [3:0] key);
    int k;
    k = 0;
    while (doneCnt == doneMark && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk("done", 16'(doneCnt - doneMark), 16'h0001);
    chk("check", lastCheck, chkExp);
    chk("sense", {senseCode, senseKey}, {code, key});
    if (chkExp) begin
      senseTaken <= 1'b1;
      @(posedge clk);
      senseTaken <= 1'b0;
      @(posedge clk);
      chk("sense cleared", {senseCode, senseKey}, 16'h0000);
    end
  endtask

  task automatic rdchk(input int len, input int nGot, input int ofs, input bit slow);
    issue(`SDBD_OP_RDBUF, 3'h0, 16'(len));
    sdbd_initiator_inst.recv(got, 8 * len + 20, slow);
    endcmd(1'b0, 8'h00, 4'h0);
    chk("read count", 16'(got.size()), 16'(nGot));
    for (int i = 0; i < got.size(); i++)
      chk("read byte", got[i], i == 2 ? 16'h0020 : i < 4 ? 16'h0000 : pat(i - 4 + ofs));
  endtask

  task automatic wr(input int len, input int bad, input bit slow);
    issue(`SDBD_OP_WRBUF, 3'h0, 16'(len));
    sdbd_initiator_inst.send(stream, bad, slow, taken);
  endtask

  task automatic t_loop();
    mk(12, 0);
    wr(12, -1, 1'b1);
    endcmd(1'b0, 8'h00, 4'h0);
    chk("write taken", 16'(taken), 16'h000c);
    rdchk(12, 12, 0, 1'b0);
    rdchk(7, 7, 0, 1'b1);
  endtask

  // Reset in the middle of a read must leave the block idle and ready for the next command
  task automatic t_reset();
    issue(`SDBD_OP_RDBUF, 3'h0, 16'h000c);
    sdbd_initiator_inst.recv(got, 3, 1'b0);
    chk("reset part", 16'(got.size()), 16'h0002);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("reset idle", {cdbReady, inReady, outValid, cmdDone, senseCode, senseKey}, 16'h8000);
    rdchk(5, 5, 0, 1'b0);
  endtask

  task automatic t_trunc();
    mk(4 + BUF + 2, 0);
    wr(1000, -1, 1'b0);
    endcmd(1'b0, 8'h00, 4'h0);
    chk("write capped", 16'(taken), 16'(4 + BUF));
    rdchk(1000, 4 + BUF, 0, 1'b1);
  endtask

  task automatic t_zero();
    mk(1, 0);
    wr(0, -1, 1'b0);
    endcmd(1'b0, 8'h00, 4'h0);
    chk("zero write", 16'(taken), 16'h0000);
    rdchk(0, 0, 0, 1'b0);
  endtask

  task automatic t_param();
    mk(4, 0);
    stream[2] = 8'h01;
    wr(8, -1, 1'b0);
    endcmd(1'b1, `SDBD_ERR_FIELD, `SDBD_KEY_ILLEGAL);
    mk(6, 100);
    wr(8, 5, 1'b0);
    endcmd(1'b1, `SDBD_ERR_PARITY, `SDBD_KEY_HWERR);
    issue(`SDBD_OP_RDBUF, 3'h0, 16'h0006);
    sdbd_initiator_inst.recv(got, 80, 1'b0);
    endcmd(1'b0, 8'h00, 4'h0);
    chk("good byte", got[4], pat(100));
    chk("bad byte dropped", got[5], pat(1));
  endtask

  task automatic t_errors();
    logic [7:0] ops[5] = '{8'h3c, 8'h3b, 8'h3c, 8'h3b, 8'h12};
    logic [2:0] luns[5] = '{3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
    logic thr[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic dfl[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0] code[5] = '{8'h25, 8'h2c, 8'h19, 8'h00, 8'h20};
    logic [3:0] key[5] = '{4'h5, 4'h6, 4'h1, 4'h0, 4'h5};
    for (int i = 0; i < 5; i++) begin
      thresholdExceeded <= thr[i];
      defectListFail <= dfl[i];
      issue(ops[i], luns[i], 16'h0000);
      endcmd(code[i] != 8'h00, code[i], key[i]);
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    cdbValid = 1'b0;
    cdb = '0;
    thresholdExceeded = 1'b0;
    defectListFail = 1'b0;
    senseTaken = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("idle", {cdbReady, inReady, outValid, cmdDone, senseCode, senseKey}, 16'h8000);
    t_loop();
    t_reset();
    t_trunc();
    t_zero();
    t_param();
    t_errors();
    conclude();
  end
endmodule // tb
